// file: mbf_defines.svh
// Purpose: constants for the serial slave function handler
// Assumes: 20 MHz system clock
// Notes: codes, limits and gap timing
`ifndef MBF_DEFINES_SVH
`define MBF_DEFINES_SVH
// ----------------------------------------
// Function and exception codes
// ----------------------------------------
`define MBF_FN_READ 8'h03
`define MBF_FN_WRITE1 8'h06
`define MBF_FN_ECHO 8'h08
`define MBF_FN_WRITEN 8'h10
`define MBF_FN_ERR_BIT 8'h80
`define MBF_EX_FUNC 8'h01
`define MBF_EX_ADDR 8'h02
`define MBF_EX_VALUE 8'h03
`define MBF_EX_FAIL 8'h04
// ----------------------------------------
// Addresses, markers and check word
// ----------------------------------------
`define MBF_ADDR_BCAST 8'h00
`define MBF_ADDR_P2P 8'hfa
`define MBF_CRC_POLY 16'ha001
`define MBF_CRC_INIT 16'hffff
`define MBF_NAN_HI 16'h7fc0
`define MBF_NAN_LO 16'h0000
`define MBF_OVL_HI 16'h7fff
`define MBF_OVL_LO 16'hffff
`define MBF_CMD_BASE 16'hff00
`define MBF_NOF6_A 8'h03
`define MBF_NOF6_B 8'hff
// ----------------------------------------
// Per-variant limits: narrow, medium, wide
// ----------------------------------------
`define MBF_RD_MAX_N 16'h0004
`define MBF_RD_MAX_M 16'h0028
`define MBF_RD_MAX_W 16'h0078
`define MBF_WR_MAX_N 16'h0002
`define MBF_WR_MAX_M 16'h0028
`define MBF_WR_MAX_W 16'h0078
`define MBF_BUF_N 9'h00d
`define MBF_BUF_M 9'h064
`define MBF_BUF_W 9'h0fa
// ----------------------------------------
// Inter-character gap timing
// ----------------------------------------
`define MBF_CLK_HZ 64'd20000000
`define MBF_CHAR_BITS 64'd11
`define MBF_BAUD_LO 64'd9600
`define MBF_GAP_CHARS_X10 64'd15
`define MBF_GAP_HI_US 64'd750
`define MBF_GAP_LO_CYC ((`MBF_GAP_CHARS_X10*`MBF_CHAR_BITS*`MBF_CLK_HZ)/(64'd10*`MBF_BAUD_LO))
`define MBF_GAP_HI_CYC ((`MBF_GAP_HI_US*`MBF_CLK_HZ)/64'd1000000)
`endif

// file: mbf_handler.sv
// Purpose: slave function handler for read, write, echo and multi-write
// Assumes: byte receiver and transmitter on the same clock
// Notes: register map answers combinationally from REG_ADDR_OUT
`timescale 1ns/1ns
`default_nettype none
`include "mbf_defines.svh"
// Overview of operation
// RQ1: Read request carries start address and count; reply returns consecutive registers.
// RQ2: Read reply has byte count twice registers, each word high byte first.
// RQ3: Read count above variant limit gives illegal data value exception.
// RQ4: Bad start address or count not fitting range gives exception 2.
// RQ5: Undefined registers inside a read come back as zero words.
// RQ6: Master reads two-register values whole within one request.
// RQ7: Bad or inactive channel reads as NaN for floats, overflow for integers.
// RQ8: Single write stores one word and echoes the request fields.
// RQ9: Single write to 0x03xx, 0xffxx or float registers gives exception 2.
// RQ10: Write to protected register gives exception 4.
// RQ11: Write data outside allowed range gives exception 4.
// RQ12: Echo with zero subfunction replies with an identical frame.
// RQ13: Nonzero echo subfunction gives code 1, or 3 on narrow variant.
// RQ14: Multi-write reply carries address, code, start address and count.
// RQ15: Multi-write limited to 2, 40 or 120 registers by variant.
// RQ16: Multi-write with bad amount or byte count mismatch gives exception 3.
// RQ17: Multi-write with undefined start address gives exception 2.
// RQ18: Multi-write reply count reports registers actually written.
// RQ19: Writes above 0xff00 trigger device commands instead of storing.
// RQ20: Master writes two-register values together in one multi-write.
// RQ21: Exception reply is address, code with top bit set, error code.
// RQ22: Broadcast requests are executed but never answered.
// RQ23: Bad check word, error or overflow discards frame silently.
// RQ24: Character gap beyond limit marks frame incomplete and discards it.
// RQ25: Check word is sent low byte first.
// RQ26: Buffer variant parameter selects count limits and echo error code.
// RQ27: Check word is reflected 0xa001 with all-ones start over frame.
module mbf_handler #(
    parameter mbf_pkg::mbf_variant_t VARIANT = mbf_pkg::MBF_WIDE,
    parameter int unsigned GAP_LO_CYC = 32'(`MBF_GAP_LO_CYC),
    parameter int unsigned GAP_HI_CYC = 32'(`MBF_GAP_HI_CYC)
) (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    // Configuration
    input wire logic [7:0] SLAVE_BUS_ADDRESS_IN,
    input wire logic BAUD_HIGH_IN,
    // Received byte stream
    input wire logic [7:0] RX_DATA_IN,
    input wire logic RX_VALID_IN,
    input wire logic RX_ERR_IN,
    input wire logic FRAME_END_IN,
    // Transmitted byte stream
    output logic [7:0] TX_DATA_OUT,
    output logic TX_VALID_OUT,
    input wire logic TX_READY_IN,
    // Register map port
    output logic [15:0] REG_ADDR_OUT,
    output logic [15:0] REG_WDATA_OUT,
    output logic REG_WE_OUT,
    output logic REG_CMD_OUT,
    input wire logic [15:0] REG_RDATA_IN,
    input wire logic REG_DEFINED_IN,
    input wire logic REG_FLOAT_IN,
    input wire logic REG_PAIR_IN,
    input wire logic REG_PROTECTED_IN,
    input wire logic REG_RANGE_OK_IN,
    input wire logic REG_CHAN_BAD_IN
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    mbf_pkg::mbf_state_t state_q, state_d;
    logic [7:0] rx_buf_q [0:255];
    logic [7:0] rx_buf_d [0:255];
    logic [7:0] tx_buf_q [0:255];
    logic [7:0] tx_buf_d [0:255];
    logic [8:0] rx_len_q, rx_len_d;
    logic rx_bad_q, rx_bad_d, bcast_q, bcast_d;
    logic [15:0] gap_q, gap_d, crc_q, crc_d, addr_q, addr_d, wdata_q, wdata_d;
    logic [7:0] tx_len_q, tx_len_d, tx_pos_q, tx_pos_d, tx_byte_q, tx_byte_d;
    logic [7:0] cnt_q, cnt_d, idx_q, idx_d, exc, fcode, p;
    logic we, cmd, done, last, pair, cmd_hit, frame_ok;
    logic [15:0] word, cnt16, rd_max, wr_max, gap_lim;
    logic [8:0] buf_max;
    logic [7:0] echo_code, fn;

    // Bitwise CRC step, LSB first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ `MBF_CRC_POLY) : (r >> 1); // RQ27
        end
        return r;
    endfunction : crc_step

    // Variant limits, fixed at build time
    always_comb begin
        case (VARIANT) // RQ26
            mbf_pkg::MBF_NARROW: begin
                rd_max = `MBF_RD_MAX_N;
                wr_max = `MBF_WR_MAX_N;
                buf_max = `MBF_BUF_N;
                echo_code = `MBF_EX_VALUE;
            end
            mbf_pkg::MBF_MEDIUM: begin
                rd_max = `MBF_RD_MAX_M;
                wr_max = `MBF_WR_MAX_M;
                buf_max = `MBF_BUF_M;
                echo_code = `MBF_EX_FUNC; // RQ13
            end
            default: begin
                rd_max = `MBF_RD_MAX_W;
                wr_max = `MBF_WR_MAX_W;
                buf_max = `MBF_BUF_W;
                echo_code = `MBF_EX_FUNC;
            end
        endcase
    end

    // Frame fields and map decode helpers
    assign gap_lim = BAUD_HIGH_IN ? 16'(GAP_HI_CYC) : 16'(GAP_LO_CYC);
    assign fn = rx_buf_q[1];
    assign cnt16 = {rx_buf_q[4], rx_buf_q[5]};
    assign frame_ok = !rx_bad_q && (crc_q == 16'h0000) && (rx_len_q >= 9'h004)
        && (rx_buf_q[0] == SLAVE_BUS_ADDRESS_IN || rx_buf_q[0] == `MBF_ADDR_BCAST
        || rx_buf_q[0] == `MBF_ADDR_P2P); // RQ23
    assign last = (idx_q == cnt_q - 8'h01);
    assign pair = REG_PAIR_IN || REG_FLOAT_IN;
    assign cmd_hit = addr_q > `MBF_CMD_BASE; // RQ19
    assign p = 8'({idx_q[6:0], 1'b0}) + 8'h09;

    // Next-state logic for the whole handler
    always_comb begin
        state_d = state_q;
        rx_buf_d = rx_buf_q;
        tx_buf_d = tx_buf_q;
        rx_len_d = rx_len_q;
        rx_bad_d = rx_bad_q;
        gap_d = gap_q;
        crc_d = crc_q;
        tx_len_d = tx_len_q;
        tx_pos_d = tx_pos_q;
        tx_byte_d = tx_byte_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        bcast_d = bcast_q;
        exc = 8'h00;
        fcode = 8'h00;
        word = 16'h0000;
        we = 1'b0;
        cmd = 1'b0;
        done = 1'b0;
        case (state_q)
            mbf_pkg::ST_RX: begin
                if (rx_len_q != 9'h000 && gap_q != 16'hffff) begin
                    gap_d = gap_q + 16'h0001;
                end
                if (RX_ERR_IN) begin
                    rx_bad_d = 1'b1; // RQ23
                end
                if (RX_VALID_IN) begin
                    gap_d = 16'h0000;
                    if (rx_len_q != 9'h000 && gap_q > gap_lim) begin
                        rx_bad_d = 1'b1; // RQ24
                    end
                    if (rx_len_q >= buf_max) begin
                        rx_bad_d = 1'b1; // RQ23
                    end else begin
                        rx_buf_d[rx_len_q[7:0]] = RX_DATA_IN;
                        rx_len_d = rx_len_q + 9'h001;
                    end
                    crc_d = crc_step(crc_q, RX_DATA_IN); // RQ27
                end
                if (FRAME_END_IN && rx_len_q != 9'h000) begin
                    state_d = mbf_pkg::ST_PARSE;
                end
            end
            mbf_pkg::ST_PARSE: begin
                rx_len_d = 9'h000;
                rx_bad_d = 1'b0;
                gap_d = 16'h0000;
                crc_d = `MBF_CRC_INIT;
                tx_pos_d = 8'h00;
                idx_d = 8'h00;
                bcast_d = rx_buf_q[0] == `MBF_ADDR_BCAST;
                addr_d = {rx_buf_q[2], rx_buf_q[3]};
                wdata_d = fn == `MBF_FN_WRITEN ? {rx_buf_q[7], rx_buf_q[8]} : cnt16;
                for (int k = 0; k < 6; k++) begin
                    tx_buf_d[k] = rx_buf_q[k]; // RQ8 RQ12 RQ14
                end
                tx_len_d = 8'h06;
                state_d = mbf_pkg::ST_RX;
                if (frame_ok) begin
                    case (fn)
                        `MBF_FN_READ: begin
                            if (rx_len_q != 9'h008 || cnt16 == 16'h0000 || cnt16 > rd_max) begin
                                exc = `MBF_EX_VALUE; // RQ3
                            end else begin
                                cnt_d = cnt16[7:0];
                                tx_buf_d[2] = 8'({cnt16[6:0], 1'b0}); // RQ2
                                tx_len_d = 8'({cnt16[6:0], 1'b0}) + 8'h03;
                                state_d = mbf_pkg::ST_LOOK;
                            end
                        end
                        `MBF_FN_WRITE1: begin
                            if (rx_len_q != 9'h008) begin
                                exc = `MBF_EX_VALUE;
                            end else begin
                                cnt_d = 8'h01;
                                state_d = mbf_pkg::ST_LOOK;
                            end
                        end
                        `MBF_FN_ECHO: begin
                            if (rx_len_q != 9'h008) begin
                                exc = `MBF_EX_VALUE;
                            end else if ((rx_buf_q[2] | rx_buf_q[3]) != 8'h00) begin
                                exc = echo_code; // RQ13
                            end else begin
                                done = 1'b1; // RQ12
                            end
                        end
                        `MBF_FN_WRITEN: begin
                            if (cnt16 == 16'h0000 || cnt16 > wr_max
                                || {1'b0, rx_buf_q[6]} != {cnt16[7:0], 1'b0}
                                || rx_len_q != {1'b0, rx_buf_q[6]} + 9'h009) begin
                                exc = `MBF_EX_VALUE; // RQ15 RQ16
                            end else begin
                                cnt_d = cnt16[7:0];
                                state_d = mbf_pkg::ST_LOOK;
                            end
                        end
                        default: exc = `MBF_EX_FUNC;
                    endcase
                end
            end
            mbf_pkg::ST_LOOK: begin
                case (fn)
                    `MBF_FN_READ: begin
                        if (idx_q == 8'h00 && (!REG_DEFINED_IN || (pair && addr_q[0]))) begin
                            exc = `MBF_EX_ADDR; // RQ4
                        end else if (last && REG_DEFINED_IN && pair && !addr_q[0]) begin
                            exc = `MBF_EX_ADDR; // RQ4
                        end else begin
                            if (!REG_DEFINED_IN) begin
                                word = 16'h0000; // RQ5
                            end else if (REG_CHAN_BAD_IN && REG_FLOAT_IN) begin
                                word = addr_q[0] ? `MBF_NAN_LO : `MBF_NAN_HI; // RQ7
                            end else if (REG_CHAN_BAD_IN) begin
                                word = (pair && addr_q[0]) ? `MBF_OVL_LO : `MBF_OVL_HI; // RQ7
                            end else begin
                                word = REG_RDATA_IN; // RQ1
                            end
                            tx_buf_d[p - 8'h06] = word[15:8]; // RQ2
                            tx_buf_d[p - 8'h05] = word[7:0];
                            done = last;
                            idx_d = idx_q + 8'h01;
                            addr_d = addr_q + 16'h0001;
                        end
                    end
                    `MBF_FN_WRITE1: begin
                        if (addr_q[15:8] == `MBF_NOF6_A || addr_q[15:8] == `MBF_NOF6_B
                            || REG_FLOAT_IN || !REG_DEFINED_IN) begin
                            exc = `MBF_EX_ADDR; // RQ9
                        end else if (REG_PROTECTED_IN || !REG_RANGE_OK_IN) begin
                            exc = `MBF_EX_FAIL; // RQ10 RQ11
                        end else begin
                            we = 1'b1; // RQ8
                            done = 1'b1;
                        end
                    end
                    default: begin
                        // Multi-write stops at first failing word, reporting what went in
                        tx_buf_d[4] = 8'h00;
                        if (!cmd_hit && !REG_DEFINED_IN) begin
                            fcode = `MBF_EX_ADDR; // RQ17
                        end else if (!cmd_hit && (REG_PROTECTED_IN || !REG_RANGE_OK_IN)) begin
                            fcode = `MBF_EX_FAIL; // RQ10 RQ11
                        end
                        if (fcode != 8'h00) begin
                            if (idx_q == 8'h00) begin
                                exc = fcode;
                            end else begin
                                tx_buf_d[5] = idx_q; // RQ18
                                done = 1'b1;
                            end
                        end else begin
                            cmd = cmd_hit; // RQ19
                            we = !cmd_hit;
                            tx_buf_d[5] = cnt_q; // RQ14
                            done = last;
                            idx_d = idx_q + 8'h01;
                            addr_d = addr_q + 16'h0001;
                            wdata_d = {rx_buf_q[p], rx_buf_q[p + 8'h01]};
                        end
                    end
                endcase
            end
            mbf_pkg::ST_TXLD: begin
                tx_byte_d = tx_buf_q[0];
                state_d = mbf_pkg::ST_TX;
            end
            mbf_pkg::ST_TX: begin
                if (TX_READY_IN) begin
                    crc_d = crc_step(crc_q, tx_byte_q); // RQ27
                    if (tx_pos_q + 8'h01 == tx_len_q) begin
                        tx_byte_d = crc_d[7:0]; // RQ25
                        state_d = mbf_pkg::ST_CRCL;
                    end else begin
                        tx_pos_d = tx_pos_q + 8'h01;
                        tx_byte_d = tx_buf_q[tx_pos_q + 8'h01];
                    end
                end
            end
            mbf_pkg::ST_CRCL: begin
                if (TX_READY_IN) begin
                    tx_byte_d = crc_q[15:8]; // RQ25
                    state_d = mbf_pkg::ST_CRCH;
                end
            end
            mbf_pkg::ST_CRCH: begin
                if (TX_READY_IN) begin
                    crc_d = `MBF_CRC_INIT;
                    state_d = mbf_pkg::ST_RX;
                end
            end
            default: state_d = mbf_pkg::ST_RX;
        endcase
        if (exc != 8'h00) begin
            tx_buf_d[1] = fn | `MBF_FN_ERR_BIT; // RQ21
            tx_buf_d[2] = exc;
            tx_len_d = 8'h03;
            done = 1'b1;
        end
        // Broadcast executes fully but skips the reply
        if (done) begin
            state_d = bcast_d ? mbf_pkg::ST_RX : mbf_pkg::ST_TXLD; // RQ22
        end
    end

    // Control registers
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            state_q <= mbf_pkg::ST_RX;
            rx_len_q <= 9'h000;
            rx_bad_q <= 1'b0;
            bcast_q <= 1'b0;
            gap_q <= 16'h0000;
            crc_q <= `MBF_CRC_INIT;
            addr_q <= 16'h0000;
            wdata_q <= 16'h0000;
            tx_len_q <= 8'h00;
            tx_pos_q <= 8'h00;
            tx_byte_q <= 8'h00;
            cnt_q <= 8'h00;
            idx_q <= 8'h00;
        end else begin
            state_q <= state_d;
            rx_len_q <= rx_len_d;
            rx_bad_q <= rx_bad_d;
            bcast_q <= bcast_d;
            gap_q <= gap_d;
            crc_q <= crc_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            tx_len_q <= tx_len_d;
            tx_pos_q <= tx_pos_d;
            tx_byte_q <= tx_byte_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
        end
    end

    // Frame buffers, data only, no reset needed
    always_ff @(posedge SYS_CLK_IN) begin
        rx_buf_q <= rx_buf_d;
        tx_buf_q <= tx_buf_d;
    end

    // Outputs
    assign TX_DATA_OUT = tx_byte_q;
    assign TX_VALID_OUT = state_q inside {mbf_pkg::ST_TX, mbf_pkg::ST_CRCL, mbf_pkg::ST_CRCH};
    assign REG_ADDR_OUT = addr_q;
    assign REG_WDATA_OUT = wdata_q;
    assign REG_WE_OUT = we;
    assign REG_CMD_OUT = cmd;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic [7:0] crc_hi;
    assign crc_hi = crc_q[15:8];
    logic is_parse;
    assign is_parse = state_q == mbf_pkg::ST_PARSE;
    sequence s_crc_lo_sent;
        state_q == mbf_pkg::ST_CRCL && TX_READY_IN;
    endsequence
    sequence s_crc_hi_shown;
        TX_DATA_OUT == $past(crc_hi) && state_q == mbf_pkg::ST_CRCH;
    endsequence
    property p_crc_order;
        s_crc_lo_sent |=> s_crc_hi_shown;
    endproperty
    a_crc_order: assert property (p_crc_order) else $error("check high byte misplaced"); // RQ25
    property p_bcast_silent;
        (is_parse && rx_buf_q[0] == `MBF_ADDR_BCAST) |=> !TX_VALID_OUT [*8];
    endproperty
    a_bcast_silent: assert property (p_bcast_silent) else $error("broadcast answered"); // RQ22
    property p_bad_crc;
        (is_parse && crc_q != 16'h0000) |=> state_q == mbf_pkg::ST_RX && !TX_VALID_OUT;
    endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("bad frame not discarded"); // RQ23
    property p_gap;
        (state_q == mbf_pkg::ST_RX && RX_VALID_IN && rx_len_q != 9'h000 && gap_q > gap_lim)
            |=> rx_bad_q;
    endproperty
    a_gap: assert property (p_gap) else $error("long gap not flagged"); // RQ24
    property p_exc_shape;
        (exc != 8'h00) |=> tx_len_q == 8'h03 && tx_buf_q[1][7] && tx_buf_q[2] == $past(exc);
    endproperty
    a_exc_shape: assert property (p_exc_shape) else $error("exception reply malformed"); // RQ21
    property p_rd_limit;
        (is_parse && frame_ok && fn == `MBF_FN_READ && rx_len_q == 9'h008 && cnt16 > rd_max)
            |=> tx_buf_q[2] == `MBF_EX_VALUE && tx_buf_q[1] == 8'h83;
    endproperty
    a_rd_limit: assert property (p_rd_limit) else $error("read limit not enforced"); // RQ3
    property p_we_guard;
        REG_WE_OUT |-> REG_DEFINED_IN && !REG_PROTECTED_IN && REG_RANGE_OK_IN && !REG_CMD_OUT;
    endproperty
    a_we_guard: assert property (p_we_guard) else $error("guarded register written"); // RQ10
    property p_f6_block;
        (state_q == mbf_pkg::ST_LOOK && fn == `MBF_FN_WRITE1 && addr_q[15:8] == `MBF_NOF6_A)
            |-> !REG_WE_OUT ##1 tx_buf_q[2] == `MBF_EX_ADDR;
    endproperty
    a_f6_block: assert property (p_f6_block) else $error("blocked range written"); // RQ9
    property p_cmd_high;
        REG_CMD_OUT |-> addr_q > `MBF_CMD_BASE && !REG_WE_OUT;
    endproperty
    a_cmd_high: assert property (p_cmd_high) else $error("command strobe out of range"); // RQ19
endmodule : mbf_handler
`default_nettype wire

// file: mbf_handler_tb.sv
// Purpose: self-checking bench for the function handler
// Assumes: wide variant, slave address 0x11
// Notes: map model answers from the address; only 0x03 is protected
`timescale 1ns/1ns
`default_nettype none
module mbf_handler_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] ra, wd;
    logic we, cmd, tv, rv, fe, tr;
    logic [7:0] td, rd;
    logic [31:0] wr_q = 32'h0;
    int miscompares = 0;
    int n_compared = 0;
    int n_cmd = 0;
    // ------------------------------
    // Clock, parts and map model
    // ------------------------------
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        if (we) wr_q <= {ra, wd};
        if (cmd) n_cmd <= n_cmd + 1;
    end
    mbf_master i_master (.clk_in(clk), .rx_data_out(rd), .rx_valid_out(rv), .frame_end_out(fe),
        .tx_data_in(td), .tx_valid_in(tv), .tx_ready_out(tr));
    mbf_handler #(.GAP_LO_CYC(20), .GAP_HI_CYC(10)) i_dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst),
        .SLAVE_BUS_ADDRESS_IN(8'h11), .BAUD_HIGH_IN(1'b0), .RX_DATA_IN(rd), .RX_VALID_IN(rv),
        .RX_ERR_IN(1'b0), .FRAME_END_IN(fe), .TX_DATA_OUT(td), .TX_VALID_OUT(tv),
        .TX_READY_IN(tr), .REG_ADDR_OUT(ra), .REG_WDATA_OUT(wd), .REG_WE_OUT(we),
        .REG_CMD_OUT(cmd), .REG_RDATA_IN(ra ^ 16'h5a5a),
        .REG_CHAN_BAD_IN(ra[15:1] == 15'h2 || ra == 16'h0003),
        .REG_DEFINED_IN(ra < 16'h0008 || ra[15:8] == 8'hff), .REG_FLOAT_IN(ra[15:1] == 15'h2),
        .REG_PAIR_IN(ra[15:1] == 15'h2), .REG_PROTECTED_IN(ra == 16'h0003),
        .REG_RANGE_OK_IN(wd != 16'hffff));
    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Send, await reply, compare bytes
    task automatic xact(input logic [95:0] q, input int nq, input logic [95:0] e, input int ne,
            input logic bad);
        logic [7:0] r[$];
        logic [7:0] x[$];
        logic [15:0] c;
        for (int i = nq - 1; i >= 0; i--) r.push_back(q[8*i+:8]);
        for (int i = ne - 1; i >= 0; i--) x.push_back(e[8*i+:8]);
        c = i_master.crc(x);
        if (ne > 0) x = {x, c[7:0], c[15:8]};
        i_master.send(r, bad);
        repeat (400) if (i_master.got_q.size() < x.size()) @(posedge clk);
        repeat (8) @(posedge clk);
        check("reply length", 16'(i_master.got_q.size()), 16'(x.size()));
        foreach (x[i])
            if (i < i_master.got_q.size()) check("reply byte", {8'h0, i_master.got_q[i]}, {8'h0, x[i]});
    endtask : xact
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_echo_read();
        i_master.slow_q = 1'b1;
        xact(96'h1108_0000_a53c, 6, 96'h1108_0000_a53c, 6, 1'b0);
        i_master.slow_q = 1'b0;
        xact(96'h1108_0001_1234, 6, 96'h1188_01, 3, 1'b0);
        xact(96'h1103_0006_0004, 6, 96'h1103_08_5a5c_5a5d_0000_0000, 11, 1'b0);
        xact(96'h1103_0000_0079, 6, 96'h1183_03, 3, 1'b0);
        xact(96'h1103_0004_0001, 6, 96'h1183_02, 3, 1'b0);
        xact(96'h1103_0003_0003, 6, 96'h1103_06_7fff_7fc0_0000, 9, 1'b0);
        $display("test echo and read done");
    endtask : t_echo_read
    task automatic t_write();
        xact(96'h1106_0301_0001, 6, 96'h1186_02, 3, 1'b0);
        xact(96'h1106_0004_0001, 6, 96'h1186_02, 3, 1'b0);
        xact(96'h1106_0003_0001, 6, 96'h1186_04, 3, 1'b0);
        xact(96'h1106_0002_ffff, 6, 96'h1186_04, 3, 1'b0);
        xact(96'h1106_0001_1234, 6, 96'h1106_0001_1234, 6, 1'b0);
        check("stored word", wr_q[31:16] ^ wr_q[15:0], 16'h1235);
        xact(96'h1110_0000_0002_04_0102_0304, 11, 96'h1110_0000_0002, 6, 1'b0);
        xact(96'h1110_0002_0002_04_0102_0304, 11, 96'h1110_0002_0001, 6, 1'b0);
        xact(96'h1110_0000_0003_04_0102_0304, 11, 96'h1190_03, 3, 1'b0);
        xact(96'h1110_0000_0079_02_0102, 9, 96'h1190_03, 3, 1'b0);
        xact(96'h1110_0010_0001_02_0102, 9, 96'h1190_02, 3, 1'b0);
        xact(96'h1110_ff01_0001_02_0007, 9, 96'h1110_ff01_0001, 6, 1'b0);
        check("command strobes", 16'(n_cmd), 16'h0001);
        check("store skipped", wr_q[31:16], 16'h0002);
        $display("test write done");
    endtask : t_write
    task automatic t_silent();
        xact(96'h0008_0000_1234, 6, 96'h0, 0, 1'b0);
        xact(96'h1108_0000_1234, 6, 96'h0, 0, 1'b1);
        xact(96'h1208_0000_1234, 6, 96'h0, 0, 1'b0);
        xact(96'h0006_0001_4321, 6, 96'h0, 0, 1'b0);
        check("broadcast store", wr_q[15:0], 16'h4321);
        $display("test silent done");
    endtask : t_silent
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_echo_read();
        t_write();
        t_silent();
        finish_test();
    end
    initial begin
        #2000000;
        miscompares++;
        finish_test();
    end
endmodule : mbf_handler_tb
`default_nettype wire

// file: mbf_master.sv
// Purpose: bus master model facing the function handler
// Assumes: one clock; reply ready may stall
// Notes: idle data shows the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module mbf_master (
    // Clock
    input wire logic clk_in,
    // Request bytes
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    output logic frame_end_out,
    // Reply bytes
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out
);
    logic [7:0] got_q[$];
    logic slow_q = 1'b0;
    // Check word over a frame
    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc
    // Whole frame in wire order; one read by the caller splits a pair to test exception 2
    task automatic send(input logic [7:0] f[$], input logic bad);
        logic [15:0] c;
        c = crc(f);
        if (bad) c = ~c;
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        got_q = {};
        foreach (f[i]) begin
            @(negedge clk_in);
            rx_data_out = f[i];
            rx_valid_out = 1'b1;
            @(negedge clk_in);
            rx_valid_out = 1'b0;
            rx_data_out = ~f[i]; // Stale value must not look valid
        end
        frame_end_out = 1'b1;
        @(negedge clk_in);
        frame_end_out = 1'b0;
    endtask : send
    // Idle levels; slow or prompt reply accept
    initial {rx_data_out, rx_valid_out, frame_end_out, tx_ready_out} = 11'h001;
    always @(negedge clk_in) tx_ready_out <= slow_q ? ~tx_ready_out : 1'b1;
    always @(posedge clk_in) if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
endmodule : mbf_master
`default_nettype wire

// file: mbf_pkg.sv
// Purpose: types for the function handler
// Assumes: nothing
// Notes: one-hot state codes
package mbf_pkg;
    typedef enum logic [6:0] {
        ST_RX = 7'h01,
        ST_PARSE = 7'h02,
        ST_LOOK = 7'h04,
        ST_TXLD = 7'h08,
        ST_TX = 7'h10,
        ST_CRCL = 7'h20,
        ST_CRCH = 7'h40
    } mbf_state_t;
    typedef enum logic [1:0] {
        MBF_NARROW = 2'h0,
        MBF_MEDIUM = 2'h1,
        MBF_WIDE = 2'h2
    } mbf_variant_t;
endpackage : mbf_pkg
